// [rtl/ssee_pkg.sv]
package ssee_pkg;
    // Opcodes, most significant bit first on the wire
    localparam logic [7:0] WRITE_LATCH_SET_CMD = 8'h06;
    localparam logic [7:0] STATUS_WRITE_CMD    = 8'h01;
    localparam logic [7:0] STATUS_READ_CMD     = 8'h05;
    localparam logic [7:0] ARRAY_READ_CMD      = 8'h03;

    // Rising clock edges in each instruction header
    localparam logic [5:0] CMD_EDGES    = 6'h08;
    localparam logic [5:0] STW_EDGES    = 6'h10;
    localparam logic [5:0] RD_HDR_EDGES = 6'h20;

    // Status byte layout
    localparam int         BUSY_BIT     = 0;
    localparam int         LATCH_BIT    = 1;
    localparam int         GUARD_LO_BIT = 2;
    localparam int         GUARD_HI_BIT = 3;
    localparam int         LOCK_BIT     = 7;
    localparam logic [7:0] STATUS_RST   = 8'h00;

    // Array address width and guarded region bases
    localparam int          ARR_AW       = 17;
    localparam logic [16:0] QUARTER_BASE = 17'h18000;
    localparam logic [16:0] HALF_BASE    = 17'h10000;
    localparam logic [16:0] WHOLE_BASE   = 17'h00000;

    // Timing: system clock and timed_write_duration
    localparam int unsigned SYS_PERIOD_NS = 5;
    localparam int unsigned TW_US         = 5000;
    localparam int unsigned TW_CYC        = TW_US * 1000 / SYS_PERIOD_NS;

    // Host serial clock half period and miso sample phase, in cycles
    localparam int unsigned HOST_HALF      = 4;
    localparam int unsigned MISO_SAMPLE_PH = 2;
endpackage

// [rtl/ssee_link_if.sv]
`timescale 1ns/1ps
interface ssee_link_if;
    logic sclk;       // Serial clock, made by the host
    logic cs_n;       // Select, active low
    logic mosi;       // Host to device data
    logic miso;       // Device data out
    logic miso_oe_n;  // Device drives miso while low
    logic guard_n;    // Write guard pin, active low
    logic miso_line;  // Resolved wire level, pulled high

    // Released line floats high
    assign miso_line = miso_oe_n ? 1'b1 : miso;

    modport host (output sclk, cs_n, mosi, guard_n, input miso_line);
    modport dev  (input sclk, cs_n, mosi, guard_n,
                  output miso, miso_oe_n);
endinterface

// [rtl/ssee_sync.sv]
`timescale 1ns/1ps
module ssee_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rstn,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_r;  // First stage, read only by o_q

    // Two flip-flop level synchroniser
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            meta_r <= '0;
            o_q    <= '0;
        end else begin
            meta_r <= i_d;
            o_q    <= meta_r;
        end
    end
endmodule // ssee_sync

// [rtl/ssee_dev_end.sv]
`timescale 1ns/1ps
module ssee_dev_end #(
    parameter int unsigned TW_CYC = ssee_pkg::TW_CYC
) (
    input  wire logic                         i_clk_sys,
    input  wire logic                         i_rstn,
    ssee_link_if.dev                          lk,
    output logic [ssee_pkg::ARR_AW-1:0]       o_arr_addr,
    input  wire logic [7:0]                   i_arr_data,
    output logic [7:0]                        o_status,
    output logic                              o_hard_guard,
    output logic                              o_guard_en,
    output logic [ssee_pkg::ARR_AW-1:0]       o_guard_base
);
    localparam int TW_W = $clog2(TW_CYC + 1);

    typedef enum logic {ST_IDLE, ST_BUSY} ssee_wst_t;

    // Link side state
    logic        start_r;   // Set while deselected
    logic [5:0]  cnt_r;     // Rising edges in frame, saturating
    logic [5:0]  cnt_nxt;
    logic [23:0] in_r;      // Serial input shifter
    logic [7:0]  op_r;      // Captured opcode
    logic [7:0]  dat_r;     // Captured status data byte
    logic        frm_r;     // Toggles once per clocked frame
    logic        rd_on_r;   // Array read streaming
    logic        st_on_r;   // Status read streaming
    logic [2:0]  obit_r;    // Output bit index
    logic [7:0]  st_l;      // Status seen in link domain
    logic [7:0]  st_q;      // Synchroniser output
    logic [7:0]  st_p_r;    // Previous synced status
    logic [7:0]  st_ok_r;   // Synced status seen twice
    logic        oe_n_r;    // Output enable, low drives
    logic        miso_r;    // Output bit
    logic [6:0]  osh_r;     // Output shifter

    // System side state
    ssee_wst_t         state_r;
    ssee_wst_t         state_nxt;
    logic [TW_W-1:0]   tmr_r;     // Remaining write cycles
    logic              wel_r;     // write_latch_flag
    logic              lock_r;    // status_lock_bit
    logic [1:0]        bp_r;      // block_guard_hi, block_guard_lo
    logic [7:0]        pend_r;    // Data held during timed cycle
    logic              cs_d_r;    // Previous synced select
    logic              seen_r;    // Last frame toggle handled
    logic [2:0]        s_q;       // Synced select, frame, pin
    logic [ssee_pkg::ARR_AW-1:0] gbase;

    // Serial input path
    wire [23:0] in_nxt = {in_r[22:0], lk.mosi};
    assign cnt_nxt = start_r ? 6'h01 :
                     (&cnt_r) ? cnt_r : cnt_r + 6'h01;
    wire op_hit = cnt_nxt == ssee_pkg::CMD_EDGES;
    wire rd_go  = cnt_nxt == ssee_pkg::RD_HDR_EDGES &&
                  op_r == ssee_pkg::ARRAY_READ_CMD &&
                  !st_l[ssee_pkg::BUSY_BIT];
    wire st_go  = op_hit && in_nxt[7:0] == ssee_pkg::STATUS_READ_CMD;
    wire out_on = rd_on_r || st_on_r;
    wire [7:0] src = rd_on_r ? i_arr_data : st_l;

    // Frame start flag, set while select is high
    always_ff @(posedge lk.sclk or posedge lk.cs_n) begin
        if (lk.cs_n) begin
            start_r <= 1'b1;
        end else begin
            start_r <= 1'b0;
        end
    end

    always_ff @(posedge lk.sclk or negedge i_rstn) begin
        if (!i_rstn) begin
            in_r  <= 24'h000000;
            cnt_r <= 6'h00;
            op_r  <= 8'h00;
            dat_r <= 8'h00;
            frm_r <= 1'b0;
        end else begin
            in_r  <= in_nxt;
            cnt_r <= cnt_nxt;
            if (start_r) begin
                frm_r <= ~frm_r;
            end
            if (op_hit) begin
                op_r <= in_nxt[7:0];
            end
            if (cnt_nxt == ssee_pkg::STW_EDGES) begin
                dat_r <= in_nxt[7:0];
            end
        end
    end

    // Read streaming control, cleared at frame start
    always_ff @(posedge lk.sclk or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_on_r <= 1'b0;
            st_on_r <= 1'b0;
            obit_r  <= 3'h0;
        end else if (start_r) begin
            rd_on_r <= 1'b0;
            st_on_r <= 1'b0;
            obit_r  <= 3'h0;
        end else begin
            if (rd_go) begin
                rd_on_r <= 1'b1;
            end
            if (st_go) begin
                st_on_r <= 1'b1;
            end
            if (out_on) begin
                obit_r <= obit_r + 3'h1;
            end
        end
    end

    // Array address register
    always_ff @(posedge lk.sclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_arr_addr <= '0;
        end else if (rd_go) begin
            o_arr_addr <= in_nxt[ssee_pkg::ARR_AW-1:0];
        end else if (rd_on_r && !start_r && obit_r == 3'h7) begin
            o_arr_addr <= o_arr_addr + 17'h00001;
        end
    end

    always_ff @(negedge lk.sclk or posedge lk.cs_n) begin
        if (lk.cs_n) begin
            oe_n_r <= 1'b1;
            miso_r <= 1'b0;
            osh_r  <= 7'h00;
        end else begin
            oe_n_r <= ~out_on;
            if (obit_r == 3'h0) begin
                {miso_r, osh_r} <= src;
            end else begin
                {miso_r, osh_r} <= {osh_r, 1'b0};
            end
        end
    end

    assign lk.miso      = miso_r;
    assign lk.miso_oe_n = oe_n_r;

    // Status into the link domain
    ssee_sync #(.W(8)) u_st_sync (
        .i_clk  (lk.sclk),
        .i_rstn (i_rstn),
        .i_d    (o_status),
        .o_q    (st_q)
    );

    // Word crossing: take only a value seen on two edges
    always_ff @(posedge lk.sclk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_p_r  <= 8'h00;
            st_ok_r <= ssee_pkg::STATUS_RST;
        end else begin
            st_p_r <= st_q;
            if (st_q == st_p_r) begin
                st_ok_r <= st_q;
            end
        end
    end
    assign st_l = st_ok_r;

    // Select, frame toggle and guard pin into system domain
    ssee_sync #(.W(3)) u_in_sync (
        .i_clk  (i_clk_sys),
        .i_rstn (i_rstn),
        .i_d    ({lk.cs_n, frm_r, lk.guard_n}),
        .o_q    (s_q)
    );

    wire cs_s  = s_q[2];
    wire frm_s = s_q[1];
    wire grd_s = s_q[0];
    wire idle  = state_r == ST_IDLE;
    // Frame end with at least one clock edge, handled once
    wire done  = cs_s && !cs_d_r && (frm_s != seen_r);
    wire hard  = lock_r && !grd_s;
    wire go_latch = done && idle &&
                    op_r == ssee_pkg::WRITE_LATCH_SET_CMD &&
                    cnt_r == ssee_pkg::CMD_EDGES;
    wire go_stw = done && idle &&
                  op_r == ssee_pkg::STATUS_WRITE_CMD &&
                  cnt_r == ssee_pkg::STW_EDGES && wel_r && !hard;
    wire tw_end = !idle && tmr_r == '0;

    assign gbase = (bp_r == 2'h1) ? ssee_pkg::QUARTER_BASE :
                   (bp_r == 2'h2) ? ssee_pkg::HALF_BASE :
                   ssee_pkg::WHOLE_BASE;

    // Write cycle sequencing
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: if (go_stw) state_nxt = ST_BUSY;
            ST_BUSY: if (tw_end) state_nxt = ST_IDLE;
        endcase
    end

    // Frame edge tracking and state register
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            state_r <= ST_IDLE;
            cs_d_r  <= 1'b0;
            seen_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cs_d_r  <= cs_s;
            if (done) begin
                seen_r <= frm_s;
            end
        end
    end

    // Timed write counter
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            tmr_r <= '0;
        end else if (go_stw) begin
            tmr_r <= TW_W'(TW_CYC - 1);
        end else if (!tw_end && !idle) begin
            tmr_r <= tmr_r - TW_W'(1);
        end
    end

    // Latch and nonvolatile status bits
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            wel_r  <= 1'b0;
            lock_r <= ssee_pkg::STATUS_RST[ssee_pkg::LOCK_BIT];
            bp_r   <= 2'h0;
            pend_r <= 8'h00;
        end else begin
            if (go_latch) begin
                wel_r <= 1'b1;
            end else if (tw_end) begin
                wel_r <= 1'b0;
            end
            if (go_stw) begin
                pend_r <= dat_r;
            end
            if (tw_end) begin
                lock_r <= pend_r[ssee_pkg::LOCK_BIT];
                bp_r   <= {pend_r[ssee_pkg::GUARD_HI_BIT],
                           pend_r[ssee_pkg::GUARD_LO_BIT]};
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_status     <= ssee_pkg::STATUS_RST;
            o_hard_guard <= 1'b0;
            o_guard_en   <= 1'b0;
            o_guard_base <= ssee_pkg::WHOLE_BASE;
        end else begin
            o_status     <= {lock_r, 3'h0, bp_r, wel_r, !idle};
            o_hard_guard <= hard;
            o_guard_en   <= |bp_r;
            o_guard_base <= gbase;
        end
    end
endmodule // ssee_dev_end

// [rtl/ssee_host_end.sv]
`timescale 1ns/1ps
module ssee_host_end #(
    parameter int unsigned HALF = ssee_pkg::HOST_HALF
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rstn,
    ssee_link_if.host        lk,
    input  wire logic        i_cmd_valid,
    input  wire logic [7:0]  i_cmd_op,
    input  wire logic [23:0] i_cmd_addr,
    input  wire logic [7:0]  i_cmd_data,
    input  wire logic [7:0]  i_cmd_len,
    input  wire logic        i_guard_n,
    output logic             o_cmd_ready,
    output logic             o_rd_valid,
    output logic [7:0]       o_rd_data
);
    typedef enum logic [2:0] {
        H_IDLE, H_SEL, H_SHIFT, H_END, H_GAP
    } ssee_hst_t;

    ssee_hst_t   st_r;      // Frame state
    ssee_hst_t   st_nxt;
    logic [7:0]  ph_r;      // Half period phase
    logic [31:0] sh_r;      // Outgoing bits
    logic [11:0] cnt_r;     // Rising edges sent
    logic [11:0] tot_r;     // Edges in this frame
    logic [11:0] hdr_r;     // Header edges in this frame
    logic [7:0]  rx_r;      // Incoming bits
    logic        sclk_r;    // Serial clock out
    logic        cs_n_r;    // Select out
    logic        grd_r;     // Guard pin out
    logic        miso_s;    // Synced device data

    // Command decode
    wire is_rd = i_cmd_op == ssee_pkg::ARRAY_READ_CMD;
    wire is_sr = i_cmd_op == ssee_pkg::STATUS_READ_CMD;
    wire is_sw = i_cmd_op == ssee_pkg::STATUS_WRITE_CMD;
    wire [11:0] hdr_w = is_rd ? 12'(ssee_pkg::RD_HDR_EDGES) :
                        is_sw ? 12'(ssee_pkg::STW_EDGES) :
                        12'(ssee_pkg::CMD_EDGES);
    wire [11:0] tot_w = (is_rd || is_sr) ?
                        hdr_w + {1'b0, i_cmd_len, 3'h0} : hdr_w;
    wire [31:0] load_w = is_rd ? {i_cmd_op, i_cmd_addr} :
                         {i_cmd_op, i_cmd_data, 16'h0000};

    wire ph_end = ph_r == 8'(HALF - 1);
    wire accept = st_r == H_IDLE && i_cmd_valid;
    wire rise   = st_r == H_SHIFT && ph_end && !sclk_r;
    wire fall   = st_r == H_SHIFT && ph_end && sclk_r;
    wire smp    = st_r == H_SHIFT && sclk_r &&
                  ph_r == 8'(ssee_pkg::MISO_SAMPLE_PH);
    wire [7:0] rx_nxt = {rx_r[6:0], miso_s};

    // Frame sequencing
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            H_IDLE:  if (i_cmd_valid) st_nxt = H_SEL;
            H_SEL:   if (ph_end) st_nxt = H_SHIFT;
            H_SHIFT: if (fall && cnt_r == tot_r) st_nxt = H_END;
            H_END:   if (ph_end) st_nxt = H_GAP;
            H_GAP:   if (ph_end) st_nxt = H_IDLE;
            default: st_nxt = H_IDLE;
        endcase
    end

    // State, phase and ready
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            st_r        <= H_IDLE;
            ph_r        <= 8'h00;
            o_cmd_ready <= 1'b0;
        end else begin
            st_r        <= st_nxt;
            ph_r        <= (st_r == H_IDLE || ph_end) ? 8'h00 :
                           ph_r + 8'h01;
            o_cmd_ready <= st_nxt == H_IDLE;
        end
    end

    // Pins: clock divider, select, data
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            sclk_r <= 1'b0;
            cs_n_r <= 1'b1;
            grd_r  <= 1'b1;
            sh_r   <= 32'h00000000;
        end else begin
            grd_r <= i_guard_n;
            if (rise || fall) begin
                sclk_r <= ~sclk_r;
            end
            if (accept) begin
                cs_n_r <= 1'b0;
            end else if (st_r == H_END && ph_end) begin
                cs_n_r <= 1'b1;
            end
            if (accept) begin
                sh_r <= load_w;
            end else if (fall) begin
                sh_r <= {sh_r[30:0], 1'b0};
            end
        end
    end

    // Edge counting and receive
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            cnt_r      <= 12'h000;
            tot_r      <= 12'h000;
            hdr_r      <= 12'h000;
            rx_r       <= 8'h00;
            o_rd_valid <= 1'b0;
            o_rd_data  <= 8'h00;
        end else begin
            o_rd_valid <= 1'b0;
            if (accept) begin
                cnt_r <= 12'h000;
                tot_r <= tot_w;
                hdr_r <= hdr_w;
            end else if (rise) begin
                cnt_r <= cnt_r + 12'h001;
            end
            if (smp) begin
                rx_r <= rx_nxt;
                if (cnt_r > hdr_r && cnt_r[2:0] == 3'h0) begin
                    o_rd_valid <= 1'b1;
                    o_rd_data  <= rx_nxt;
                end
            end
        end
    end

    // Device data pin into system domain
    ssee_sync #(.W(1)) u_miso_sync (
        .i_clk  (i_clk_sys),
        .i_rstn (i_rstn),
        .i_d    (lk.miso_line),
        .o_q    (miso_s)
    );

    assign lk.sclk    = sclk_r;
    assign lk.cs_n    = cs_n_r;
    assign lk.mosi    = sh_r[31];
    assign lk.guard_n = grd_r;
endmodule // ssee_host_end

// [tb/ssee_link_asserts.sv]
`timescale 1ns/1ps
module ssee_link_asserts (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe_n,
    input wire logic guard_n,
    input wire logic miso_line
);
    // All link checks sampled by the system clock
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    property p_sclk_idle; cs_n |-> !sclk; endproperty
    a_sclk_idle: assert property (p_sclk_idle)
        else $error("sclk high while deselected");
    property p_cs_gap; $rose(cs_n) |=> cs_n [*4]; endproperty
    a_cs_gap: assert property (p_cs_gap)
        else $error("select gap too short");
    property p_cs_edge; $changed(cs_n) |-> !sclk; endproperty
    a_cs_edge: assert property (p_cs_edge)
        else $error("select moved with sclk high");
    property p_mosi_hold; sclk && $past(sclk) |-> $stable(mosi);
    endproperty
    a_mosi_hold: assert property (p_mosi_hold)
        else $error("mosi moved while sclk high");
    property p_half; $rose(sclk) |-> sclk [*4] ##1 !sclk; endproperty
    a_half: assert property (p_half)
        else $error("sclk high phase length wrong");
    property p_oe_start; $fell(miso_oe_n) |-> $fell(sclk); endproperty
    a_oe_start: assert property (p_oe_start)
        else $error("miso driven off a falling edge");
    property p_miso_fall;
        !miso_oe_n && $past(!miso_oe_n) && $changed(miso) |-> $fell(sclk);
    endproperty
    a_miso_fall: assert property (p_miso_fall)
        else $error("miso changed off a falling edge");
    property p_oe_sel; !miso_oe_n |-> !cs_n && miso_line == miso;
    endproperty
    a_oe_sel: assert property (p_oe_sel)
        else $error("miso driven while deselected");
    property p_release; $rose(cs_n) |-> miso_oe_n [*4]; endproperty
    a_release: assert property (p_release)
        else $error("miso not released after select");

    // Main traffic shapes
    c_drive: cover property ($fell(miso_oe_n));
    c_frame: cover property ($rose(cs_n));
    c_pin: cover property ($fell(guard_n));
endmodule // ssee_link_asserts

// [tb/tb_spi_eeprom_status_write_and_read.sv]
`timescale 1ns/1ps
module tb_spi_eeprom_status_write_and_read;
    localparam int TW = 1000;          // Shortened timed write
    logic        i_clk_sys;
    logic        i_rstn;
    logic        cmd_valid;            // Host request
    logic        guard_n;              // Guard pin level to host
    logic [7:0]  cmd_op;
    logic [7:0]  cmd_data;
    logic [7:0]  cmd_len;
    logic [23:0] cmd_addr;
    logic        cmd_ready;
    logic        rd_valid;
    logic [7:0]  rd_data;
    logic [7:0]  arr_data;
    logic [7:0]  status;
    logic [16:0] arr_addr;
    logic [16:0] guard_base;
    logic        hard_guard;
    logic        guard_en;
    logic [7:0]  d;
    logic [23:0] a;
    logic        m_lock;               // Model status bits
    logic        m_latch;
    int          m_gd;
    int          n_errors;
    int          num_checks;
    logic [7:0]  q[$];                 // Received bytes

    ssee_link_if lk ();

    // Memory content, a function of address
    function automatic logic [7:0] mem(logic [16:0] x);
        return x[7:0] ^ {x[16:10], 1'b1};
    endfunction
    assign arr_data = mem(arr_addr);

    ssee_host_end ssee_host_end_inst (.i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn), .lk(lk.host), .i_cmd_valid(cmd_valid),
        .i_cmd_op(cmd_op), .i_cmd_addr(cmd_addr), .i_cmd_data(cmd_data),
        .i_cmd_len(cmd_len), .i_guard_n(guard_n),
        .o_cmd_ready(cmd_ready), .o_rd_valid(rd_valid),
        .o_rd_data(rd_data));
    ssee_dev_end #(.TW_CYC(TW)) ssee_dev_end_inst (
        .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .lk(lk.dev),
        .o_arr_addr(arr_addr), .i_arr_data(arr_data), .o_status(status),
        .o_hard_guard(hard_guard), .o_guard_en(guard_en),
        .o_guard_base(guard_base));
    ssee_link_asserts ssee_link_asserts_inst (.i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn), .sclk(lk.sclk), .cs_n(lk.cs_n), .mosi(lk.mosi),
        .miso(lk.miso), .miso_oe_n(lk.miso_oe_n), .guard_n(lk.guard_n),
        .miso_line(lk.miso_line));

    // 200 MHz clock
    initial begin
        i_clk_sys = 1'b0;
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end

    task automatic close_out;
        if (n_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk_byte(string nm, logic [7:0] e, logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic chk_base(string nm, logic [16:0] e, logic [16:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask

    // Inputs move just after the edge
    task automatic tick(int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask

    // Wait for host idle, gathering bytes
    task automatic settle;
        for (int k = 0; cmd_ready !== 1'b1; k++) begin
            if (k > 6000) begin
                n_errors++;
                close_out;
            end
            if (rd_valid === 1'b1) q.push_back(rd_data);
            tick(1);
        end
    endtask

    task automatic do_cmd(logic [7:0] op, logic [23:0] ad,
                          logic [7:0] dt, logic [7:0] ln);
        settle;
        cmd_op = op;
        cmd_addr = ad;
        cmd_data = dt;
        cmd_len = ln;
        cmd_valid = 1'b1;
        tick(1);
        cmd_valid = 1'b0;
        q = {};
        settle;
    endtask

    function automatic logic [7:0] m_st(logic busy);
        return {m_lock, 3'b000, 2'(m_gd), m_latch, busy};
    endfunction

    task automatic rd_st(logic [7:0] e);
        do_cmd(8'h05, 24'h000000, 8'h00, 8'h01);
        chk_byte("status_read", e, q[0]);
    endtask

    // Busy flag must drop within a bounded time
    task automatic wait_idle;
        tick(8);
        for (int k = 0; status[0] !== 1'b0; k++) begin
            if (k > 3 * TW) begin
                n_errors++;
                close_out;
            end
            tick(1);
        end
        tick(2);
    endtask

    task automatic chk_guard;
        logic [16:0] b;
        b = (m_gd == 1) ? ssee_pkg::QUARTER_BASE :
            (m_gd == 2) ? ssee_pkg::HALF_BASE : ssee_pkg::WHOLE_BASE;
        chk_byte("hard_guard", {7'h00, m_lock & ~guard_n},
                 {7'h00, hard_guard});
        chk_byte("guard_en", {7'h00, m_gd != 0}, {7'h00, guard_en});
        chk_base("guard_base", b, guard_base);
        chk_byte("o_status", m_st(1'b0), status);
    endtask

    // Latch set, then status write; model follows acceptance
    task automatic stw(logic [7:0] dt);
        do_cmd(8'h06, 24'h000000, 8'h00, 8'h00);
        m_latch = 1'b1;
        do_cmd(8'h01, 24'h000000, dt, 8'h00);
        tick(10);
        if (!(m_lock && !guard_n)) begin
            wait_idle;
            m_lock = dt[7];
            m_gd = int'(dt[3:2]);
            m_latch = 1'b0;
        end
    endtask

    task automatic ard(logic [23:0] ad, int n);
        do_cmd(8'h03, ad, 8'h00, 8'(n));
        for (int i = 0; i < n; i++)
            chk_byte("array_read", mem(ad[16:0] + 17'(i)), q[i]);
    endtask

    // Hang guard
    initial begin
        repeat (100000) @(posedge i_clk_sys);
        n_errors++;
        close_out;
    end

    initial begin
        {cmd_valid, cmd_op, cmd_data, cmd_len, cmd_addr} = '0;
        {i_rstn, guard_n, m_lock, m_latch, m_gd} = '0;
        guard_n = 1'b1;
        n_errors = 0;
        num_checks = 0;
        void'($urandom(32'h98FA));
        repeat (12) @(posedge i_clk_sys);
        #1;
        i_rstn = 1'b1;
        rd_st(m_st(1'b0));
        do_cmd(8'h01, 24'h000000, 8'h8C, 8'h00);
        tick(20);
        chk_guard;
        do_cmd(8'h06, 24'h000000, 8'h00, 8'h00);
        m_latch = 1'b1;
        rd_st(m_st(1'b0));
        do_cmd(8'h01, 24'h000000, 8'hFF, 8'h00);
        rd_st(m_st(1'b1));
        do_cmd(8'h03, 24'h000010, 8'h00, 8'h01);
        chk_byte("read_busy", 8'hFF, q[0]);
        wait_idle;
        m_lock = 1'b1;
        m_gd = 3;
        m_latch = 1'b0;
        rd_st(m_st(1'b0));
        chk_guard;
        guard_n = 1'b0;
        tick(10);
        chk_guard;
        stw(8'h00);
        rd_st(m_st(1'b0));
        guard_n = 1'b1;
        tick(10);
        chk_guard;
        // Guard codes 1 to 3 written, code 0 blocked by the hard guard, pin level varied
        for (int i = 0; i < 4; i++) begin
            guard_n = i[0];
            d = 8'($urandom);
            d[7] = 1'b0;
            d[3:2] = 2'(i);
            stw(d);
            chk_guard;
        end
        guard_n = 1'b0;
        stw(8'h84);
        tick(10);
        chk_guard;
        guard_n = 1'b1;
        tick(10);
        stw(8'h00);
        chk_guard;
        a = 24'($urandom);
        a[16:0] = 17'h1FFFE;
        ard(a, 4);
        ard(24'($urandom), 3);
        close_out;
    end
endmodule // tb_spi_eeprom_status_write_and_read
